// >>> inc/vintu_pkg.sv
`default_nettype none
package vintu_pkg;
   localparam int VINTU_NSRC = 10;
   localparam int VINTU_PCW  = 10;
   // Source indices, lowest vector first
   localparam int SRC_TMR  = 0;
   localparam int SRC_EXTA = 1;
   localparam int SRC_EXTB = 2;
   localparam int SRC_CNT1 = 3;
   localparam int SRC_CNT2 = 4;
   localparam int SRC_HPT  = 5;
   localparam int SRC_LPT  = 6;
   localparam int SRC_PCHG = 7;
   localparam int SRC_PPER = 8;
   localparam int SRC_PDUT = 9;
   localparam logic [9:0] VEC_TMR  = 10'h003;
   localparam logic [9:0] VEC_EXTA = 10'h006;
   localparam logic [9:0] VEC_EXTB = 10'h009;
   localparam logic [9:0] VEC_CNT1 = 10'h00c;
   localparam logic [9:0] VEC_CNT2 = 10'h00f;
   localparam logic [9:0] VEC_HPT  = 10'h012;
   localparam logic [9:0] VEC_LPT  = 10'h015;
   localparam logic [9:0] VEC_PCHG = 10'h018;
   localparam logic [9:0] VEC_PPER = 10'h01e;
   localparam logic [9:0] VEC_PDUT = 10'h021;
   // Register offsets on the plain register port
   localparam logic [3:0] OFS_FLAG_LO = 4'h0;
   localparam logic [3:0] OFS_FLAG_HI = 4'h1;
   localparam logic [3:0] OFS_MASK    = 4'h2;
   localparam logic [3:0] OFS_PWM_EN  = 4'h3;
   localparam logic [3:0] OFS_STATUS  = 4'h4;
   // Banked PWM enable bit positions
   localparam int PWM_EN_PER_BIT = 2;
   localparam int PWM_EN_DUT_BIT = 1;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [9:0] RST_VEC  = 10'h000;
   typedef enum logic [2:0]
   {
      VI_IDLE = 3'b001,
      VI_SAVE = 3'b010,
      VI_SERV = 3'b100
   } vintu_state_t;
endpackage
`default_nettype wire

// >>> hdl/vintu_edge.sv
`timescale 1ns/1ps
`default_nettype none
module vintu_edge
   import vintu_pkg::*;
#(
   parameter int WIDTH = 10
)
(
   input  wire logic             clock_i,
   input  wire logic             sys_rst_i,
   input  wire logic [WIDTH-1:0] level_i,
   output logic      [WIDTH-1:0] fall_o
);
   logic [WIDTH-1:0] prev;

   // Starts high so a line already low at reset is taken as a fall once reset ends
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         prev <= '1;
      else
         prev <= level_i;
   end

   assign fall_o = prev & ~level_i;
endmodule
`default_nettype wire

// >>> hdl/vintu_core.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - A falling source signal sets its flag only while its enable is set: mask bit for sources 0 to 7, PWM enable bit for 8 and 9.
// - Flag register holds one pending bit per source, readable by software.
// - Mask register holds one enable for each of sources 0 to 7; masked requests never flag or vector.
// - Enable instruction sets global enable, disable clears it; cleared blocks redirection.
// - Accepted request redirects next fetch to its vector, 0003H through 0021H.
// - Every source has its own distinct fixed vector.
// - Timer 0003H, external pin a 0006H, external pin b 0009H.
// - Counter one 000CH, counter two 000FH.
// - High-pulse timer 0012H, low-pulse timer 0015H.
// - Port input change vectors to 0018H.
// - PWM period match 001EH, PWM duty match 0021H.
// - Each of the four down counters raises its own request on underflow.
// - Accumulator and status word are saved before the handler's first instruction.
// - Saved accumulator and status word are restored when the handler completes.
// - No vectoring to another handler while one executes.
// - Requests during a handler stay pending until it completes.
// - Mask bits 0 to 6: timer, pin a, pin b, counter1, counter2, high, low.
// - Mask bit 7 set: port change interrupts; cleared: wake only.
// - PWM period and duty enables at bits 2 and 1 of a separate register.
module vintu_core
   import vintu_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       sys_rst_i,
   input  wire logic       tmr_ovf_n_i,
   input  wire logic       ext_irq_pin_a_i,
   input  wire logic       ext_irq_pin_b_i,
   input  wire logic       cnt1_udf_n_i,
   input  wire logic       cnt2_udf_n_i,
   input  wire logic       hpt_udf_n_i,
   input  wire logic       lpt_udf_n_i,
   input  wire logic       port_chg_n_i,
   input  wire logic       pwm_per_n_i,
   input  wire logic       pwm_dut_n_i,
   input  wire logic       global_irq_on_instr_i,
   input  wire logic       global_irq_off_instr_i,
   input  wire logic       fetch_slot_i,
   input  wire logic       handler_done_i,
   input  wire logic [7:0] working_reg_i,
   input  wire logic [7:0] status_word_reg_i,
   input  wire logic [3:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   output logic            vector_load_o,
   output logic      [9:0] vector_addr_o,
   output logic            save_o,
   output logic            restore_o,
   output logic      [7:0] working_reg_o,
   output logic      [7:0] status_word_reg_o,
   output logic            wake_o,
   output logic            in_handler_o
);
   logic [VINTU_NSRC-1:0] level;
   logic [VINTU_NSRC-1:0] fall;
   logic [VINTU_NSRC-1:0] irq_flag_reg;
   logic [VINTU_NSRC-1:0] enable_vec;
   logic [VINTU_NSRC-1:0] clr_vec;
   logic [VINTU_NSRC-1:0] ack_vec;
   logic [7:0]            irq_mask_reg;
   logic [7:0]            pwm_en_reg;
   logic                  gie;
   vintu_state_t          state;
   logic                  pick_valid;
   logic [3:0]            pick_idx;
   logic [9:0]            pick_vec;
   logic                  take;

   assign level = {pwm_dut_n_i, pwm_per_n_i, port_chg_n_i, lpt_udf_n_i, hpt_udf_n_i,
                   cnt2_udf_n_i, cnt1_udf_n_i, ext_irq_pin_b_i, ext_irq_pin_a_i,
                   tmr_ovf_n_i};

   vintu_edge #(.WIDTH(VINTU_NSRC)) u_edge
   (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .level_i   (level),
      .fall_o    (fall)
   );

   // Mask bits 0..7 map straight; PWM enables come from the banked register
   assign enable_vec = {pwm_en_reg[PWM_EN_DUT_BIT], pwm_en_reg[PWM_EN_PER_BIT],
                        irq_mask_reg};

   always_comb
   begin
      clr_vec = '0;
      if (reg_wr_i && reg_addr_i == OFS_FLAG_LO)
         clr_vec[7:0] = ~reg_wdata_i;
      else if (reg_wr_i && reg_addr_i == OFS_FLAG_HI)
         clr_vec[9:8] = ~reg_wdata_i[1:0];
   end

   // Priority pick: lowest index is lowest vector
   always_comb
   begin
      pick_valid = 1'b0;
      pick_idx   = 4'h0;
      for (int i = VINTU_NSRC - 1; i >= 0; i--)
      begin
         if (irq_flag_reg[i] && enable_vec[i])
         begin
            pick_valid = 1'b1;
            pick_idx   = 4'(i);
         end
      end
   end

   always_comb
   begin
      case (pick_idx)
         4'h0: pick_vec = VEC_TMR;
         4'h1: pick_vec = VEC_EXTA;
         4'h2: pick_vec = VEC_EXTB;
         4'h3: pick_vec = VEC_CNT1;
         4'h4: pick_vec = VEC_CNT2;
         4'h5: pick_vec = VEC_HPT;
         4'h6: pick_vec = VEC_LPT;
         4'h7: pick_vec = VEC_PCHG;
         4'h8: pick_vec = VEC_PPER;
         default: pick_vec = VEC_PDUT;
      endcase
   end

   // Only from idle, with global enable, at a fetch slot
   assign take = (state == VI_IDLE) && gie && pick_valid && fetch_slot_i;

   always_comb
   begin
      ack_vec = '0;
      if (take)
         ack_vec[pick_idx] = 1'b1;
   end

   // Set beats software clear; the taken flag is consumed by the vectoring
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         irq_flag_reg <= '0;
      else
         irq_flag_reg <= (irq_flag_reg & ~clr_vec & ~ack_vec) | (fall & enable_vec);
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         irq_mask_reg <= RST_BYTE;
      else if (reg_wr_i && reg_addr_i == OFS_MASK)
         irq_mask_reg <= reg_wdata_i;
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         pwm_en_reg <= RST_BYTE;
      else if (reg_wr_i && reg_addr_i == OFS_PWM_EN)
         pwm_en_reg <= reg_wdata_i & 8'h06;
   end

   // Disable wins when both instruction strobes coincide
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         gie <= 1'b0;
      else if (global_irq_off_instr_i)
         gie <= 1'b0;
      else if (global_irq_on_instr_i)
         gie <= 1'b1;
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         state <= VI_IDLE;
      else
      begin
         case (state)
            VI_IDLE: if (take) state <= VI_SAVE;
            VI_SAVE: state <= VI_SERV;
            VI_SERV: if (handler_done_i) state <= VI_IDLE;
            default: state <= VI_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         vector_load_o <= 1'b0;
         vector_addr_o <= RST_VEC;
      end
      else
      begin
         vector_load_o <= take;
         if (take)
            vector_addr_o <= pick_vec;
      end
   end

   // Shadow copy taken in the cycle of acceptance, before any handler fetch
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         working_reg_o     <= RST_BYTE;
         status_word_reg_o <= RST_BYTE;
      end
      else if (take)
      begin
         working_reg_o     <= working_reg_i;
         status_word_reg_o <= status_word_reg_i;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         save_o    <= 1'b0;
         restore_o <= 1'b0;
      end
      else
      begin
         save_o    <= take;
         restore_o <= (state == VI_SERV) && handler_done_i;
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         in_handler_o <= 1'b0;
      else
         in_handler_o <= (state != VI_IDLE && !(state == VI_SERV && handler_done_i)) || take;
   end

   // Port change wakes the core even with its mask bit cleared
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         wake_o <= 1'b0;
      else
         wake_o <= |fall;
   end

   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
         reg_rdata_o <= RST_BYTE;
      else if (reg_rd_i)
      begin
         if (reg_addr_i == OFS_FLAG_LO)
            reg_rdata_o <= irq_flag_reg[7:0];
         else if (reg_addr_i == OFS_FLAG_HI)
            reg_rdata_o <= {6'h00, irq_flag_reg[9:8]};
         else if (reg_addr_i == OFS_MASK)
            reg_rdata_o <= irq_mask_reg;
         else if (reg_addr_i == OFS_PWM_EN)
            reg_rdata_o <= pwm_en_reg;
         else if (reg_addr_i == OFS_STATUS)
            reg_rdata_o <= {5'h00, state == VI_SERV, state == VI_SAVE, gie};
         else
            reg_rdata_o <= RST_BYTE;
      end
      else
         reg_rdata_o <= RST_BYTE;
   end

   sequence s_accept;
      take;
   endsequence

   sequence s_vector_out;
      vector_load_o && save_o && in_handler_o;
   endsequence

   vec_range_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      vector_load_o |-> vector_addr_o >= VEC_TMR && vector_addr_o <= VEC_PDUT)
      else $error("vector outside table");
   vec_follow_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      s_accept |=> s_vector_out)
      else $error("accept not followed by vector and save");
   no_nest_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      in_handler_o |=> !vector_load_o)
      else $error("nested vectoring");
   gie_block_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !gie |=> !vector_load_o)
      else $error("vector while globally disabled");
   mask_flag_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (fall[SRC_TMR] && !irq_mask_reg[0]) |=> !$rose(irq_flag_reg[SRC_TMR]))
      else $error("masked timer flagged");
   flag_set_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (fall[SRC_EXTA] && irq_mask_reg[1]) |=> irq_flag_reg[SRC_EXTA])
      else $error("enabled fall not flagged");
   prio_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (take && irq_flag_reg[SRC_TMR] && enable_vec[SRC_TMR]) |=> vector_addr_o == VEC_TMR)
      else $error("priority not lowest vector");
   restore_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (state == VI_SERV && handler_done_i) |=> restore_o && !in_handler_o)
      else $error("no restore at handler end");
   pending_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (state == VI_SERV && irq_flag_reg[SRC_CNT1] && !handler_done_i && clr_vec == '0)
      |=> irq_flag_reg[SRC_CNT1])
      else $error("pending lost in handler");
endmodule
`default_nettype wire

// >>> dv/vintu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module vintu_core_model
(
   input  wire logic       clock_i,
   input  wire logic       sys_rst_i,
   input  wire logic       vector_load_i,
   input  wire logic       slow_i,
   input  wire logic [7:0] hlen_i,
   input  wire logic [7:0] acc_i,
   input  wire logic [7:0] stat_i,
   output logic            fetch_slot_o,
   output logic            handler_done_o,
   output logic      [7:0] working_reg_o,
   output logic      [7:0] status_word_reg_o
);
   logic [7:0] left;
   logic       phase;
   // Handler clobbers live values, so a late save would show
   assign working_reg_o     = (left != 8'h00) ? ~acc_i : acc_i;
   assign status_word_reg_o = (left != 8'h00) ? ~stat_i : stat_i;
   // Slow core offers a fetch slot only every other cycle
   assign fetch_slot_o      = ~slow_i | phase;
   always_ff @(posedge clock_i)
   begin
      if (sys_rst_i)
      begin
         left           <= 8'h00;
         phase          <= 1'b0;
         handler_done_o <= 1'b0;
      end
      else
      begin
         phase          <= ~phase;
         handler_done_o <= (left == 8'h01);
         if (vector_load_i)
            left <= hlen_i;
         else if (left != 8'h00)
            left <= left - 8'h01;
      end
   end
endmodule
`default_nettype wire

// >>> dv/vectored_interrupt_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_unit_test;
   import vintu_pkg::*;
   logic       clock_i, sys_rst_i, gon, goff, fetch, hdone, wr, rd, slow;
   logic       vload, save, restore, wake, inh;
   logic [9:0] src, vaddr;
   logic [7:0] wrk, sts, acc, stat, hlen, wdata, rdata, wsh, ssh;
   logic [3:0] addr;
   int         err_total, tests_run;
   localparam logic [9:0] EXP_VEC [0:9] = '{10'h003, 10'h006, 10'h009, 10'h00c, 10'h00f,
                                            10'h012, 10'h015, 10'h018, 10'h01e, 10'h021};
   vintu_core DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .tmr_ovf_n_i(src[0]),
      .ext_irq_pin_a_i(src[1]), .ext_irq_pin_b_i(src[2]), .cnt1_udf_n_i(src[3]),
      .cnt2_udf_n_i(src[4]), .hpt_udf_n_i(src[5]), .lpt_udf_n_i(src[6]),
      .port_chg_n_i(src[7]), .pwm_per_n_i(src[8]), .pwm_dut_n_i(src[9]),
      .global_irq_on_instr_i(gon), .global_irq_off_instr_i(goff), .fetch_slot_i(fetch),
      .handler_done_i(hdone), .working_reg_i(wrk), .status_word_reg_i(sts),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .vector_load_o(vload), .vector_addr_o(vaddr), .save_o(save),
      .restore_o(restore), .working_reg_o(wsh), .status_word_reg_o(ssh), .wake_o(wake),
      .in_handler_o(inh));
   vintu_core_model CORE (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .vector_load_i(vload),
      .slow_i(slow), .hlen_i(hlen), .acc_i(acc), .stat_i(stat), .fetch_slot_o(fetch),
      .handler_done_o(hdone), .working_reg_o(wrk), .status_word_reg_o(sts));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clock_i);
      rd <= 1'b0;
      @(negedge clock_i);
      chk({24'h0, rdata}, {24'h0, exp});
   endtask
   task automatic gie(input logic on);
      @(posedge clock_i);
      gon  <= on;
      goff <= ~on;
      @(posedge clock_i);
      gon  <= 1'b0;
      goff <= 1'b0;
   endtask
   task automatic fall(input int i);
      @(posedge clock_i);
      src[i] <= 1'b0;
      @(posedge clock_i);
      src[i] <= 1'b1;
   endtask
   // Bounded wait: 0 vector load, 1 restore, 2 wake
   task automatic wait_ev(input int sel, input int n, output logic got);
      got = 1'b0;
      repeat (n)
      begin
         @(negedge clock_i);
         if ((sel == 0 && vload === 1'b1) || (sel == 1 && restore === 1'b1) ||
             (sel == 2 && wake === 1'b1))
         begin
            got = 1'b1;
            break;
         end
      end
   endtask
   task automatic t_reset;
      for (int a = 0; a < 5; a++)
         rd_reg(a[3:0], 8'h00);
      rd_reg(4'hf, 8'h00);
   endtask
   task automatic t_vectors;
      logic g;
      gie(1'b1);
      for (int i = 0; i < 10; i++)
      begin
         acc  <= 8'h10 + i[7:0];
         stat <= 8'h80 + i[7:0];
         wr_reg(OFS_MASK, (i < 8) ? (8'h01 << i) : 8'h00);
         wr_reg(OFS_PWM_EN, (i == 8) ? 8'h04 : (i == 9) ? 8'h02 : 8'h00);
         fall(i);
         wait_ev(0, 10, g);
         chk({g, save, inh, vaddr}, {3'b111, EXP_VEC[i]});
         chk({wsh, ssh}, {8'h10 + i[7:0], 8'h80 + i[7:0]});
         wait_ev(1, 40, g);
         chk({g, inh, wsh, ssh}, {2'b10, 8'h10 + i[7:0], 8'h80 + i[7:0]});
         rd_reg(OFS_FLAG_LO, 8'h00);
         rd_reg(OFS_FLAG_HI, 8'h00);
      end
   endtask
   task automatic t_masked;
      logic g;
      wr_reg(OFS_MASK, 8'h00);
      wr_reg(OFS_PWM_EN, 8'h00);
      fall(7);
      wait_ev(2, 4, g);
      chk({31'h0, g}, 32'h1);
      fall(8);
      wait_ev(0, 10, g);
      chk({31'h0, g}, 32'h0);
      rd_reg(OFS_FLAG_LO, 8'h00);
      rd_reg(OFS_FLAG_HI, 8'h00);
   endtask
   task automatic t_gie;
      logic g;
      gie(1'b0);
      rd_reg(OFS_STATUS, 8'h00);
      wr_reg(OFS_MASK, 8'h03);
      fall(0);
      fall(1);
      wait_ev(0, 10, g);
      chk({31'h0, g}, 32'h0);
      rd_reg(OFS_FLAG_LO, 8'h03);
      wr_reg(OFS_FLAG_LO, 8'hfd);
      rd_reg(OFS_FLAG_LO, 8'h01);
      gie(1'b1);
      wait_ev(0, 10, g);
      chk({g, vaddr}, {1'b1, 10'h003});
      rd_reg(OFS_STATUS, 8'h05);
      wait_ev(1, 40, g);
      chk({31'h0, g}, 32'h1);
   endtask
   task automatic t_pending;
      logic g;
      slow <= 1'b1;
      hlen <= 8'd20;
      wr_reg(OFS_MASK, 8'hff);
      fall(5);
      wait_ev(0, 10, g);
      chk({g, vaddr}, {1'b1, 10'h012});
      fall(3);
      fall(1);
      wait_ev(0, 10, g);
      chk({31'h0, g}, 32'h0);
      wait_ev(1, 40, g);
      chk({31'h0, g}, 32'h1);
      wait_ev(0, 10, g);
      chk({g, vaddr}, {1'b1, 10'h006});
      wait_ev(1, 40, g);
      chk({31'h0, g}, 32'h1);
      wait_ev(0, 10, g);
      chk({g, vaddr}, {1'b1, 10'h00c});
      wait_ev(1, 40, g);
      chk({31'h0, g}, 32'h1);
   endtask
   task automatic results;
      if (err_total == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   initial
   begin
      // Whole run is well under 2000 cycles
      #50000;
      err_total++;
      results();
   end
   initial
   begin
      err_total = 0;
      tests_run = 0;
      sys_rst_i = 1'b1;
      {gon, goff, wr, rd, slow} = 5'h00;
      src   = 10'h3ff;
      acc   = 8'h00;
      stat  = 8'h00;
      hlen  = 8'd12;
      addr  = 4'h0;
      wdata = 8'h00;
      repeat (5) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_vectors();
      t_masked();
      t_gie();
      t_pending();
      results();
   end
endmodule
`default_nettype wire
